// File: rtl/eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;
  // array geometry
  localparam int unsigned ADDR_W     = 6;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned WORDS      = 64;
  localparam int unsigned FRAME_W    = 24;
  localparam int unsigned FIFO_DEPTH = 4;
  // frame bit positions, first received bit at the top
  localparam int unsigned OP_HI      = 23;
  localparam int unsigned OP_LO      = 22;
  localparam int unsigned ADDR_HI    = 21;
  localparam int unsigned ADDR_LO    = 16;
  // opcodes and the sub-codes carried in the two upper address bits
  localparam logic [1:0] OP_READ     = 2'h2;
  localparam logic [1:0] OP_WRITE    = 2'h1;
  localparam logic [1:0] OP_ERASE    = 2'h3;
  localparam logic [1:0] OP_MISC     = 2'h0;
  localparam logic [1:0] SUB_ENABLE  = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_WRALL   = 2'h1;
  localparam logic [1:0] SUB_ERALL   = 2'h2;
  // clock counts each command must carry after the start bit, plus the value where the count saturates
  localparam logic [4:0] BITS_SHORT  = 5'h08;
  localparam logic [4:0] BITS_LONG   = 5'h18;
  localparam logic [4:0] BITS_MODE   = 5'h04;
  localparam logic [4:0] BITS_SAT    = 5'h1F;
  // reset and delivered content
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // timing
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned PROG_TYP_MS  = 4;
  localparam int unsigned PROG_MAX_MS  = 8;
  localparam int unsigned PROG_CYCLES  = PROG_TYP_MS * CLK_MHZ * 1000;
  localparam int unsigned PROG_MAX_CYC = PROG_MAX_MS * CLK_MHZ * 1000;
  // protocol states
  typedef enum logic [2:0] {
    ST_STANDBY = 3'h0,
    ST_HUNT    = 3'h1,
    ST_SHIFT   = 3'h2,
    ST_READ    = 3'h3
  } state_t;
endpackage
`default_nettype wire

// File: rtl/word_stream_if.sv
`default_nettype none
interface word_stream_if #(parameter int unsigned W = 16);
  logic         flush;
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport producer (output flush, output push_valid, input push_ready, output push_data,
                    input pop_valid, output pop_ready, input pop_data);
  modport store (input flush, input push_valid, output push_ready, input push_data,
                 output pop_valid, input pop_ready, output pop_data);
endinterface
`default_nettype wire

// File: rtl/word_fifo.sv
`default_nettype none
module word_fifo #(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic    clk_i,   // system clock
  input  wire logic    nrst_i,  // async reset, active low
  word_stream_if.store s        // push and pop sides
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0]   cnt_q;
  logic          do_push;
  logic          do_pop;

  // honest full and empty
  assign s.push_ready = (cnt_q != (PW+1)'(DEPTH));
  assign s.pop_valid  = (cnt_q != '0);
  assign s.pop_data   = mem_q[rd_q];
  assign do_push      = s.push_valid & s.push_ready;
  assign do_pop       = s.pop_valid & s.pop_ready;

  // storage writes
  always_ff @(posedge clk_i)
  begin
    if (do_push)
    begin
      mem_q[wr_q] <= s.push_data;
    end
  end

  // pointers and fill level, flush empties
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else if (s.flush)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_push)
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + PW'(1);
      if (do_pop)
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + PW'(1);
      if (do_push && !do_pop)
        cnt_q <= cnt_q + (PW+1)'(1);
      else if (do_pop && !do_push)
        cnt_q <= cnt_q - (PW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// File: rtl/serial_eeprom_command_port.sv
`default_nettype none
module serial_eeprom_command_port
#(
  parameter int unsigned PROG_CYC = eeprom_pkg::PROG_CYCLES  // self-timed cycle length
) (
  input  wire logic clk_i,              // system clock, 100 MHz
  input  wire logic nrst_i,             // async reset, active low
  input  wire logic device_select_i,    // chip select pin
  input  wire logic serial_clock_in_i,  // serial clock pin
  input  wire logic serial_data_in_i,   // serial data in pin
  input  wire logic low_supply_i,       // supply detector, high when low
  output logic      serial_data_out_o,  // serial data out level
  output logic      serial_data_oe_o    // high while driving data out
);
  import eeprom_pkg::*;

  logic [3:0]        sync1_q;
  logic [3:0]        sync2_q;
  logic              sk_prev_q;
  logic              cs_prev_q;
  logic              cs_s;
  logic              di_s;
  logic              low_s;
  logic              sk_rise;
  logic              cs_fall;
  state_t            state_q;
  logic [4:0]        cnt_q;
  logic [FRAME_W-1:0] frame_q;
  logic [1:0]        op;
  logic [1:0]        sub;
  logic              cmd_ok;
  logic              cmd_mod;
  logic              go;
  logic              prog_en_q;
  logic              busy_q;
  logic              status_q;
  logic [19:0]       timer_q;
  logic [1:0]        pend_op_q;
  logic [1:0]        pend_sub_q;
  logic [ADDR_W-1:0] pend_addr_q;
  logic [DATA_W-1:0] pend_data_q;
  logic [DATA_W-1:0] mem_q [WORDS];
  logic              pf_on_q;
  logic [ADDR_W-1:0] pf_addr_q;
  logic [DATA_W-1:0] word_q;
  logic [3:0]        left_q;
  logic              do_q;
  logic              oe_q;
  logic              start_now;
  logic              read_hit;
  logic              pop_now;

  word_stream_if #(.W(DATA_W)) ws ();

  word_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .s      (ws.store)
  );

  // two-stage synchronisers for all pins: cs, sk, di, low supply
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= {low_supply_i, serial_data_in_i, serial_clock_in_i, device_select_i};
      sync2_q <= sync1_q;
    end
  end

  // edge history on the synchronised levels
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end
    else
    begin
      sk_prev_q <= sync2_q[1];
      cs_prev_q <= sync2_q[0];
    end
  end

  assign cs_s    = sync2_q[0];
  assign di_s    = sync2_q[2];
  assign low_s   = sync2_q[3];
  assign sk_rise = sync2_q[1] & ~sk_prev_q & cs_s;
  assign cs_fall = cs_prev_q & ~cs_s;

  assign op  = frame_q[OP_HI:OP_LO];
  assign sub = frame_q[ADDR_HI:ADDR_HI-1];
  assign cmd_mod = (op == OP_WRITE) || (op == OP_ERASE) ||
                   ((op == OP_MISC) && ((sub == SUB_WRALL) || (sub == SUB_ERALL)));

  // clock count check per command, exact except a range for enable and disable
  always_comb
  begin
    cmd_ok = 1'b0;
    case (op)
      OP_WRITE: cmd_ok = (cnt_q == BITS_LONG);
      OP_ERASE: cmd_ok = (cnt_q == BITS_SHORT);
      OP_MISC:
        if (sub == SUB_WRALL)
          cmd_ok = (cnt_q == BITS_LONG);
        else if (sub == SUB_ERALL)
          cmd_ok = (cnt_q == BITS_SHORT);
        else
          cmd_ok = (cnt_q >= BITS_MODE) && (cnt_q <= BITS_SHORT);
      default: cmd_ok = 1'b0;
    endcase
  end

  // a command other than read is acted on only at select fall
  assign go = cs_fall && (state_q == ST_SHIFT) && cmd_ok;

  assign start_now = (state_q == ST_HUNT) && sk_rise && di_s && !busy_q;
  assign read_hit  = (state_q == ST_SHIFT) && sk_rise && (cnt_q == BITS_SHORT - 5'h01) &&
                     (op == OP_READ);
  assign pop_now   = (state_q == ST_READ) && sk_rise && (left_q == 4'h0) && ws.pop_valid;

  // protocol state
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state_q <= ST_STANDBY;
    else if (!cs_s)
      state_q <= ST_STANDBY;
    else
    begin
      case (state_q)
        ST_STANDBY: state_q <= ST_HUNT;
        ST_HUNT:
          if (start_now)
            state_q <= ST_SHIFT;
        ST_SHIFT:
          if (read_hit)
            state_q <= ST_READ;
        ST_READ: state_q <= ST_READ;
        default: state_q <= ST_STANDBY;
      endcase
    end
  end

  // frame capture and clock count, count saturates
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q   <= 5'h00;
      frame_q <= '0;
    end
    else if (start_now)
    begin
      cnt_q   <= 5'h00;
      frame_q <= '0;
    end
    else if ((state_q == ST_SHIFT) && sk_rise)
    begin
      if (cnt_q < BITS_LONG)
        frame_q[5'(OP_HI) - cnt_q] <= di_s;
      if (cnt_q != BITS_SAT)
        cnt_q <= cnt_q + 5'h01;
    end
  end

  // program enable mode
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      prog_en_q <= 1'b0;
    else if (low_s)
      prog_en_q <= 1'b0;
    // mode changes at select fall only, except that low supply clears it at once
    else if (go && (op == OP_MISC) && (sub == SUB_ENABLE))
      prog_en_q <= 1'b1;
    else if (go && (op == OP_MISC) && (sub == SUB_DISABLE))
      prog_en_q <= 1'b0;
  end

  // self-timed programming cycle and pending operation
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      busy_q      <= 1'b0;
      timer_q     <= 20'h00000;
      pend_op_q   <= 2'h0;
      pend_sub_q  <= 2'h0;
      pend_addr_q <= '0;
      pend_data_q <= '0;
    end
    else if (low_s)
    begin
      busy_q  <= 1'b0;
      timer_q <= 20'h00000;
    end
    else if (go && cmd_mod && prog_en_q)
    begin
      busy_q      <= 1'b1;
      timer_q     <= 20'(PROG_CYC - 1);
      pend_op_q   <= op;
      pend_sub_q  <= sub;
      pend_addr_q <= frame_q[ADDR_HI:ADDR_LO];
      pend_data_q <= frame_q[DATA_W-1:0];
    end
    // cycle ends after the fixed count
    else if (busy_q)
    begin
      if (timer_q == 20'h00000)
        busy_q <= 1'b0;
      else
        timer_q <= timer_q - 20'h00001;
    end
  end

  // status reporting armed at cycle start until next start bit
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      status_q <= 1'b0;
    else if (go && cmd_mod && prog_en_q && !low_s)
      status_q <= 1'b1;
    else if (start_now)
      status_q <= 1'b0;
  end

  // array powers up all ones; writes land at cycle end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < WORDS; i++)
        mem_q[i] <= ERASED_WORD;
    end
    else if (busy_q && !low_s && (timer_q == 20'h00000))
    begin
      for (int i = 0; i < WORDS; i++)
      begin
        if ((pend_op_q == OP_MISC) && (pend_sub_q == SUB_WRALL))
          mem_q[i] <= pend_data_q;
        else if ((pend_op_q == OP_MISC) && (pend_sub_q == SUB_ERALL))
          mem_q[i] <= ERASED_WORD;
        else if ((pend_op_q == OP_WRITE) && (pend_addr_q == ADDR_W'(i)))
          mem_q[i] <= pend_data_q;
        // erase writes all ones, no data bits
        else if ((pend_op_q == OP_ERASE) && (pend_addr_q == ADDR_W'(i)))
          mem_q[i] <= ERASED_WORD;
      end
    end
  end

  // read prefetch into the word buffer, stalls when full
  assign ws.flush      = !cs_s;
  assign ws.push_valid = pf_on_q;
  assign ws.push_data  = mem_q[pf_addr_q];
  assign ws.pop_ready  = pop_now;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pf_on_q   <= 1'b0;
      pf_addr_q <= '0;
    end
    else if (!cs_s)
      pf_on_q <= 1'b0;
    else if (read_hit)
    begin
      pf_on_q   <= 1'b1;
      pf_addr_q <= {frame_q[ADDR_HI:ADDR_LO+1], di_s};
    end
    // next address, wraps from all ones to zero
    else if (pf_on_q && ws.push_ready)
      pf_addr_q <= pf_addr_q + ADDR_W'(1);
  end

  // data out driver: read shifting, status polling, float otherwise
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      do_q   <= 1'b0;
      oe_q   <= 1'b0;
      word_q <= '0;
      left_q <= 4'h0;
    end
    else if (!cs_s)
    begin
      do_q   <= 1'b0;
      oe_q   <= 1'b0;
      left_q <= 4'h0;
    end
    // low until the next clock rise
    else if (read_hit)
    begin
      do_q   <= 1'b0;
      oe_q   <= 1'b1;
      left_q <= 4'h0;
    end
    else if (state_q == ST_READ)
    begin
      if (pop_now)
      begin
        do_q   <= ws.pop_data[DATA_W-1];
        word_q <= {ws.pop_data[DATA_W-2:0], 1'b0};
        left_q <= 4'hF;
      end
      else if (sk_rise && (left_q != 4'h0))
      begin
        do_q   <= word_q[DATA_W-1];
        word_q <= {word_q[DATA_W-2:0], 1'b0};
        left_q <= left_q - 4'h1;
      end
    end
    // start bit while ready floats at once
    else if (start_now)
    begin
      do_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if ((state_q == ST_HUNT) && status_q)
    begin
      do_q <= !busy_q;
      oe_q <= 1'b1;
    end
    else
    begin
      do_q <= 1'b0;
      oe_q <= 1'b0;
    end
  end

  assign serial_data_out_o = do_q;
  assign serial_data_oe_o  = oe_q;

  // helper: length of the current programming cycle
  logic [19:0] busy_len_q;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      busy_len_q <= 20'h00000;
    else if (busy_q)
      busy_len_q <= busy_len_q + 20'h00001;
    else
      busy_len_q <= 20'h00000;
  end

  a_standby_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cs_s |=> !oe_q && (state_q == ST_STANDBY))
    else $error("output driven or active while deselected");

  a_read_low_first: assert property (@(posedge clk_i) disable iff (!nrst_i)
    read_hit && cs_s |=> oe_q && !do_q && (state_q == ST_READ))
    else $error("read did not drive low after address");

  a_start_needs_high: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_q == ST_HUNT) && !(sk_rise && di_s) |=> state_q != ST_SHIFT)
    else $error("start taken without data high");

  a_busy_ignores: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_q == ST_HUNT) && busy_q |=> state_q != ST_SHIFT)
    else $error("command accepted during programming");

  a_prog_needs_en: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(busy_q) |-> $past(prog_en_q) && $past(cs_fall))
    else $error("programming started outside enable mode");

  a_prog_starts: assert property (@(posedge clk_i) disable iff (!nrst_i)
    go && cmd_mod && prog_en_q && !low_s |=> busy_q ##1 busy_q)
    else $error("programming did not begin at select fall");

  a_count_cancel: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_fall && (state_q == ST_SHIFT) && !cmd_ok && !busy_q |=> !busy_q)
    else $error("miscounted command started programming");

  a_prog_bound: assert property (@(posedge clk_i) disable iff (!nrst_i)
    busy_q |-> busy_len_q < 20'(PROG_MAX_CYC))
    else $error("programming exceeded its longest time");

  a_poll_busy_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_s && (state_q == ST_HUNT) && status_q && busy_q |=> oe_q && !do_q)
    else $error("busy status not low");

  a_poll_ready_hi: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_s && (state_q == ST_HUNT) && status_q && !busy_q && !start_now |=> oe_q && do_q)
    else $error("ready status not high");

  a_start_floats: assert property (@(posedge clk_i) disable iff (!nrst_i)
    start_now && status_q && cs_s |=> !oe_q && !status_q)
    else $error("output not floated on start bit");

  a_addr_wraps: assert property (@(posedge clk_i) disable iff (!nrst_i)
    pf_on_q && ws.push_ready && cs_s && !read_hit && (pf_addr_q == '1) |=> pf_addr_q == '0)
    else $error("read address did not wrap");

  c_read_entry: cover property (@(posedge clk_i) disable iff (!nrst_i) read_hit ##1 oe_q);
  c_prog_start: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(busy_q));
  c_poll_ready: cover property (@(posedge clk_i) disable iff (!nrst_i) status_q && $fell(busy_q));
  c_word_pop:   cover property (@(posedge clk_i) disable iff (!nrst_i) pop_now);
endmodule
`default_nettype wire

// File: tb/host_model.sv
`default_nettype none
module host_model
  import eeprom_pkg::*;
(
  input  wire logic clk_i,     // system clock
  output logic      select_o,  // device select
  output logic      sclk_o,    // serial clock, still between frames
  output logic      sdi_o,     // serial data to the device
  input  wire logic sdo_i,     // device data out level
  input  wire logic oe_i       // device drives data out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wire_lvl;
  logic last_q = 1'b0;
  // undriven line has no pull, so it shows the inverse of its last level
  assign wire_lvl = oe_i ? sdo_i : ~last_q;
  always_ff @(posedge clk_i)
  begin
    if (oe_i)
      last_q <= sdo_i;
  end
  // idle pins at time zero
  initial
  begin
    select_o = 1'b0;
    sclk_o   = 1'b0;
    sdi_o    = 1'b0;
  end
  // select held for a gap well over the minimum
  task sel(input logic v);
    select_o <= v;
    repeat (24) @(posedge clk_i);
  endtask
  // data set 4 clk ahead of the rise, held 4 clk after it
  task bit_io(input logic b, output logic [1:0] o);
    sdi_o <= b;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    o = {oe_i, wire_lvl};
    @(posedge clk_i);
    sclk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sclk_o <= 1'b0;
  endtask
  // left-aligned frame, first bit sent first
  task send(input logic [25:0] f, input int n);
    logic [1:0] o;
    for (int i = 0; i < n; i++)
      bit_io(f[25-i], o);
  endtask
  // select high, data low, wait for ready or the limit
  task poll(input int lim, output int n, output logic arm);
    n = 0;
    sdi_o <= 1'b0;
    sel(1'b1);
    @(negedge clk_i);
    arm = oe_i;
    while (oe_i === 1'b1 && wire_lvl === 1'b0 && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
  endtask
  // read command then two words, stalling so the prefetch buffer fills
  task read2(input logic [5:0] a, input logic fresh, output logic [1:0] flt,
             output logic [1:0] lead, output logic [31:0] w);
    logic [8:0] f;
    logic [1:0] o;
    f = {1'b1, OP_READ, a};
    if (fresh)
      sel(1'b1);
    for (int i = 8; i >= 0; i--)
    begin
      bit_io(f[i], o);
      if (i == 7)
        flt = o;
    end
    bit_io(1'b0, lead);
    repeat (64) @(posedge clk_i);
    for (int i = 31; i >= 0; i--)
    begin
      bit_io(1'b0, o);
      w[i] = o[0];
    end
    sel(1'b0);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_pkg::*;
  localparam int unsigned PC = 200;  // short self-timed cycle
  typedef struct packed {
    logic [1:0]  op;
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic [5:0]  raddr;
    logic [31:0] exp;
  } row_t;
  logic clk_i        = 1'b0;
  logic nrst_i       = 1'b0;
  logic low_supply_i = 1'b0;
  // pin nets, driven by the host model and the device outputs
  wire logic select;
  wire logic sclk;
  wire logic sdi;
  wire logic sdo;
  wire logic oe;
  int   err_count    = 0;
  int   checks_done  = 0;
  row_t rows [5] = '{
    '{OP_WRITE, 6'h05, 16'h1234, 6'h05, 32'h1234FFFF},
    '{OP_ERASE, 6'h05, 16'h0000, 6'h05, 32'hFFFFFFFF},
    '{OP_MISC, {SUB_WRALL, 4'h0}, 16'h5A5A, 6'h05, 32'h5A5A5A5A},
    '{OP_MISC, {SUB_ERALL, 4'h0}, 16'h0000, 6'h3F, 32'hFFFFFFFF},
    '{OP_WRITE, 6'h3F, 16'hC3A5, 6'h3F, 32'hC3A5FFFF}};
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  serial_eeprom_command_port #(.PROG_CYC(PC)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .device_select_i(select),
    .serial_clock_in_i(sclk), .serial_data_in_i(sdi),
    .low_supply_i(low_supply_i), .serial_data_out_o(sdo), .serial_data_oe_o(oe));
  host_model host (
    .clk_i(clk_i), .select_o(select), .sclk_o(sclk), .sdi_o(sdi),
    .sdo_i(sdo), .oe_i(oe));
  task wrap_up();
    $display("mismatches %0d, checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // frame of start, opcode, address, data; select low ends it
  task cmd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
           input int extra);
    logic wide;
    wide = (op == OP_WRITE) || (op == OP_MISC && a[5:4] == SUB_WRALL);
    host.sel(1'b1);
    if (wide)
      host.send({1'b1, op, a, d, 1'b0}, 25 + extra);
    else
      host.send({1'b1, op, a, 17'h0}, 9 + extra);
    host.sel(1'b0);
  endtask
  // status poll; select is left high
  task prog_ok(input logic want);
    int   n;
    logic arm;
    host.poll(PC + 40, n, arm);
    chk({15'h0, arm}, {15'h0, want}, "status shown");
    if (want)
    begin
      chk({15'h0, n > 0 && n <= PC}, 16'h1, "busy span");
      @(negedge clk_i);
      chk({14'h0, oe, sdo}, 16'h3, "ready shown");
      @(posedge clk_i);
    end
  endtask
  task rd(input logic [5:0] a, input logic fresh, input logic [31:0] exp);
    logic [1:0]  flt;
    logic [1:0]  lead;
    logic [31:0] w;
    host.read2(a, fresh, flt, lead, w);
    chk({15'h0, flt[1]}, 16'h0, "floating after start");
    chk({14'h0, lead}, 16'h2, "low before first bit");
    chk(w[31:16], exp[31:16], "first word");
    chk(w[15:0], exp[15:0], "next word");
  endtask
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    host.sel(1'b1);
    host.send(26'h0, 7);
    cmd(OP_MISC, {SUB_ENABLE, 4'h0}, 16'h0, 0);
    foreach (rows[i])
    begin
      cmd(rows[i].op, rows[i].addr, rows[i].wdata, 0);
      prog_ok(1'b1);
      host.sel(1'b0);
      rd(rows[i].raddr, 1'b1, rows[i].exp);
    end
    cmd(OP_WRITE, 6'h3F, 16'h1357, 0);
    prog_ok(1'b1);
    host.sel(1'b0);
    cmd(OP_WRITE, 6'h00, 16'h2468, 0);
    prog_ok(1'b1);
    // new read started while the poll shows ready
    rd(6'h3F, 1'b0, {16'h1357, 16'h2468});
    host.send({1'b1, OP_READ, 6'h00, 17'h0}, 9);
    host.sel(1'b1);
    chk({15'h0, oe}, 16'h0, "ignored while deselected");
    host.sel(1'b0);
    cmd(OP_WRITE, 6'h3F, 16'h0000, 1);
    prog_ok(1'b0);
    host.sel(1'b0);
    cmd(OP_ERASE, 6'h00, 16'h0000, -1);
    cmd(OP_WRITE, 6'h3F, 16'h0BAD, 0);
    repeat (30) @(posedge clk_i);
    low_supply_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    low_supply_i <= 1'b0;
    repeat (PC + 20) @(posedge clk_i);
    cmd(OP_WRITE, 6'h3F, 16'h0F0F, 0);
    prog_ok(1'b0);
    host.sel(1'b0);
    cmd(OP_MISC, {SUB_ENABLE, 4'h0}, 16'h0, 0);
    cmd(OP_MISC, {SUB_DISABLE, 4'h0}, 16'h0, 0);
    cmd(OP_ERASE, 6'h3F, 16'h0000, 0);
    prog_ok(1'b0);
    host.sel(1'b0);
    rd(6'h3F, 1'b1, {16'h1357, 16'h2468});
    // second reset in mid-run
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({15'h0, oe}, 16'h0, "released in reset");
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(6'h3F, 1'b1, 32'hFFFFFFFF);
    wrap_up();
  end
  // watchdog well past the expected run length
  initial
  begin
    #400000;
    err_count++;
    $display("wrong value at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
